// File: esm_top.sv
// event-driven eight-state machine with configuration byte port
`timescale 1ns/1ps
// Overview of operation
// - two to eight states, set by configuration
// - 25 inputs: 24 requests, one return
// - high request level takes its transition
// - three request inputs per destination state
// - any state may leave to all others
// - low return input forces configured initial state
// - at most 24 transitions, one per input
// - current state's table byte drives outputs
// - table bytes at 0xd0 to 0xd7 readable/writable
// - routing configuration readable and rewritable by master
// - table writes show at state change or reset
// - unsynchronised inputs, earliest valid request wins
// - new state and outputs within bounded delay
// - state changes only from input activity
// - earlier competing request wins, exactly one occurs
// - pending exit request leaves after one delay
module esm_top
    import esm_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               srst_in,
    input  wire logic [NUM_REQ-1:0] trans_req_in,
    input  wire logic               return_to_initial_n_in,
    input  wire logic               cfg_wr_in,
    input  wire logic               cfg_rd_in,
    input  wire logic [7:0]         cfg_addr_in,
    input  wire logic [7:0]         cfg_wdata_in,
    output logic      [OUT_WIDTH-1:0] state_output_out,
    output logic      [2:0]         state_out,
    output logic      [7:0]         cfg_rdata_out,
    output logic                    cfg_rvalid_out
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [NUM_REQ-1:0]              req_sync;        // filtered requests
    logic                            ret_n_sync;      // filtered return input
    logic                            rst_act;         // return-to-initial active
    logic [7:0]                      trans_cfg_reg [NUM_REQ];  // slot bytes
    logic [2:0]                      init_state_reg;  // configured initial state
    esm_state_t                      state_reg;       // current state
    logic [NUM_STATES*OUT_WIDTH-1:0] table_vec;       // output table contents
    logic                            otab_wr;         // table write strobe
    logic [NUM_REQ-1:0]              hit;             // valid exit requests
    logic                            take;            // a transition fires
    logic [4:0]                      win;             // winning slot index
    logic [2:0]                      dest;            // winning destination
    logic [7:0]                      rd_mux;          // read data selection

    ////////////////////////////////////////////////////////////////////
    // pin-side synchronisers for all 25 inputs
    esm_sync #(
        .WIDTH (NUM_REQ),
        .INIT  (1'b0)
    ) u_req_sync (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .async_in   (trans_req_in),
        .sync_out   (req_sync)
    );

    esm_sync #(
        .WIDTH (1),
        .INIT  (1'b1)
    ) u_ret_sync (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .async_in   (return_to_initial_n_in),
        .sync_out   (ret_n_sync)
    );

    // active low return input
    assign rst_act = ~ret_n_sync;

    ////////////////////////////////////////////////////////////////////
    // output table
    assign otab_wr = cfg_wr_in && (cfg_addr_in >= OTAB_BASE) && (cfg_addr_in <= OTAB_LAST);

    esm_otab u_otab (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .wr_in      (otab_wr),
        .wr_idx_in  (cfg_addr_in[2:0]),
        .wr_data_in (cfg_wdata_in),
        .table_out  (table_vec)
    );

    ////////////////////////////////////////////////////////////////////
    // transition slot configuration, slot k leads into state k/3
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            for (int k = 0; k < NUM_REQ; k++) begin
                trans_cfg_reg[k] <= TRANS_RESET;
            end
        end else if (cfg_wr_in && (cfg_addr_in <= TRANS_LAST)) begin
            trans_cfg_reg[cfg_addr_in[4:0]] <= cfg_wdata_in;
        end
    end

    // initial state selection
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            init_state_reg <= INIT_RESET;
        end else if (cfg_wr_in && (cfg_addr_in == INIT_ADDR)) begin
            init_state_reg <= cfg_wdata_in[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // valid exit requests from the current state
    always_comb begin
        for (int k = 0; k < NUM_REQ; k++) begin
            hit[k] = req_sync[k]
                  && trans_cfg_reg[k][TRANS_EN_BIT]
                  && (trans_cfg_reg[k][TRANS_SRC_LSB +: 3] == state_reg)
                  && (3'(k / REQ_PER_STATE) != state_reg);
        end
    end

    // lowest index wins among requests seen in the same cycle
    always_comb begin
        take = 1'b0;
        win  = 5'h00;
        for (int k = NUM_REQ - 1; k >= 0; k--) begin
            if (hit[k]) begin
                take = 1'b1;
                win  = 5'(k);
            end
        end
        dest = 3'(win / 5'(REQ_PER_STATE));
    end

    ////////////////////////////////////////////////////////////////////
    // state register; any change needs a request or the return input
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_reg <= esm_state_t'(INIT_RESET);
        end else if (rst_act) begin
            state_reg <= esm_state_t'(init_state_reg);
        end else if (take) begin
            // a pending exit fires on the very next cycle
            state_reg <= esm_state_t'(dest);
        end
    end

    // state observed by software and the routing matrix
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_out <= INIT_RESET;
        end else if (rst_act) begin
            state_out <= init_state_reg;
        end else if (take) begin
            state_out <= dest;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs load from the table only on a change or while in reset
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_output_out <= OTAB_ONEHOT;
        end else if (rst_act) begin
            // held in reset: written table shows at once
            state_output_out <= table_vec[init_state_reg*OUT_WIDTH +: OUT_WIDTH];
        end else if (take) begin
            state_output_out <= table_vec[dest*OUT_WIDTH +: OUT_WIDTH];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration read decode; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        if (cfg_addr_in <= TRANS_LAST) begin
            rd_mux = trans_cfg_reg[cfg_addr_in[4:0]];
        end else if (cfg_addr_in == INIT_ADDR) begin
            rd_mux = {5'h00, init_state_reg};
        end else if (cfg_addr_in == STATE_ADDR) begin
            rd_mux = {5'h00, state_reg};
        end else if (cfg_addr_in >= OTAB_BASE && cfg_addr_in <= OTAB_LAST) begin
            rd_mux = table_vec[cfg_addr_in[2:0]*OUT_WIDTH +: OUT_WIDTH];
        end
    end

    // read data register, valid one cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cfg_rdata_out  <= 8'h00;
            cfg_rvalid_out <= 1'b0;
        end else begin
            cfg_rvalid_out <= cfg_rd_in;
            if (cfg_rd_in) begin
                cfg_rdata_out <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    sequence req0_held_s;
        trans_req_in[0] [*4];
    endsequence

    sequence ret_low_s;
        !return_to_initial_n_in [*4];
    endsequence

    // a request held four cycles reaches the machine
    req_sync_path_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        req0_held_s ##1 1'b1 |-> req_sync[0])
        else $error("request not passed through synchroniser");

    // a low return input held four cycles forces the initial state
    init_force_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        ret_low_s ##1 1'b1 |=> state_reg == esm_state_t'($past(init_state_reg)))
        else $error("return input did not force initial state");

    // a firing transition lands on the slot's destination
    trans_take_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        take && !rst_act |=> state_reg == esm_state_t'($past(win) / 5'(REQ_PER_STATE)))
        else $error("transition did not reach its destination");

    // the winning slot leaves from the current state and is enabled
    slot_source_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        take |-> trans_cfg_reg[win][TRANS_EN_BIT]
              && trans_cfg_reg[win][TRANS_SRC_LSB +: 3] == state_reg
              && req_sync[win])
        else $error("winning slot not valid for current state");

    // no lower-index slot was valid when one wins
    low_index_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        take |-> (hit & ((24'h000001 << win) - 24'h000001)) == 24'h000000)
        else $error("lower index request was skipped");

    // outputs carry the destination's table byte after a transition
    out_match_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        take && !rst_act |=> state_output_out
            == $past(table_vec[dest*OUT_WIDTH +: OUT_WIDTH]))
        else $error("outputs do not match destination table entry");

    // without change or reset the outputs keep their level
    out_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !take && !rst_act |=> $stable(state_output_out) && $stable(state_reg))
        else $error("outputs or state changed without cause");

    // in reset the outputs follow a freshly written table byte
    reset_follow_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rst_act && $past(rst_act) |=> state_output_out
            == $past(table_vec[init_state_reg*OUT_WIDTH +: OUT_WIDTH]))
        else $error("outputs ignore table while held in reset");

    // table write is seen on readback two cycles later
    otab_rw_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        otab_wr ##1 (cfg_rd_in && cfg_addr_in == $past(cfg_addr_in) && !otab_wr)
        |=> cfg_rvalid_out && cfg_rdata_out == $past(cfg_wdata_in, 2))
        else $error("table byte readback mismatch");

    // state output port mirrors the internal state
    state_port_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        1'b1 |-> state_out == state_reg)
        else $error("state port out of step with state");

endmodule

// File: esm_pkg.sv
// constants and types shared by the event state machine design files
package esm_pkg;

    // machine dimensions
    localparam int NUM_STATES    = 8;   // states the machine can hold
    localparam int NUM_REQ       = 24;  // transition-request inputs
    localparam int REQ_PER_STATE = 3;   // requests grouped per destination
    localparam int OUT_WIDTH     = 8;   // outputs driven per state
    localparam int SYNC_STAGES   = 3;   // shift stages on each pin-side input, plus the filter flop

    // configuration port byte addresses
    localparam logic [7:0] TRANS_BASE = 8'h00;  // 24 transition slot bytes
    localparam logic [7:0] TRANS_LAST = 8'h17;  // last transition slot byte
    localparam logic [7:0] INIT_ADDR  = 8'h18;  // initial state select
    localparam logic [7:0] STATE_ADDR = 8'h19;  // current state, read only
    localparam logic [7:0] OTAB_BASE  = 8'hd0;  // state0_output_pattern
    localparam logic [7:0] OTAB_LAST  = 8'hd7;  // state7_output_pattern

    // transition slot byte layout
    localparam int TRANS_EN_BIT  = 7;   // slot enable
    localparam int TRANS_SRC_LSB = 0;   // source state field, 3 bits

    // reset values
    localparam logic [7:0] TRANS_RESET = 8'h00;  // all slots disabled
    localparam logic [2:0] INIT_RESET  = 3'h0;   // initial state 0
    localparam logic [7:0] OTAB_ONEHOT = 8'h01;  // state n drives output n

    // machine state codes
    typedef enum logic [2:0] {
        ESM_S0 = 3'b000,
        ESM_S1 = 3'b001,
        ESM_S2 = 3'b010,
        ESM_S3 = 3'b011,
        ESM_S4 = 3'b100,
        ESM_S5 = 3'b101,
        ESM_S6 = 3'b110,
        ESM_S7 = 3'b111
    } esm_state_t;

endpackage

// File: esm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module esm_sync
    import esm_pkg::*;
#(
    parameter int         WIDTH = 1,
    parameter logic [0:0] INIT  = 1'b0
) (
    input  wire logic             sys_clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_reg;  // first stage, read only by s2
    logic [WIDTH-1:0] s2_reg;  // second stage
    logic [WIDTH-1:0] s3_reg;  // third stage

    ////////////////////////////////////////////////////////////////////
    // shift chain
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            s1_reg <= {WIDTH{INIT}};
            s2_reg <= {WIDTH{INIT}};
            s3_reg <= {WIDTH{INIT}};
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // a bit changes only once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sync_out <= {WIDTH{INIT}};
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    sync_out[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule

// File: esm_otab.sv
// per-state output pattern table, one byte per state
`timescale 1ns/1ps
module esm_otab
    import esm_pkg::*;
(
    input  wire logic                            sys_clk_in,
    input  wire logic                            srst_in,
    input  wire logic                            wr_in,
    input  wire logic [2:0]                      wr_idx_in,
    input  wire logic [7:0]                      wr_data_in,
    output logic      [NUM_STATES*OUT_WIDTH-1:0] table_out
);

    ////////////////////////////////////////////////////////////////////
    // table storage; defaults to one-hot, byte n has bit n set
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            for (int n = 0; n < NUM_STATES; n++) begin
                table_out[n*OUT_WIDTH +: OUT_WIDTH] <= OTAB_ONEHOT << n;
            end
        end else if (wr_in) begin
            table_out[wr_idx_in*OUT_WIDTH +: OUT_WIDTH] <= wr_data_in;
        end
    end

endmodule

// File: esm_matrix_model.sv
// routing matrix stand-in that drives the request and return lines
`timescale 1ns/1ps
module esm_matrix_model
    import esm_pkg::*;
(
    input  wire logic               sys_clk_in,
    output logic      [NUM_REQ-1:0] trans_req_out,
    output logic                    ret_n_out
);
    localparam int MIN_PULSE = 4;  // cycles a pulse stands, above the filter span

    // idle: no request, return inactive
    initial begin
        trans_req_out = '0;
        ret_n_out     = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // raise one request line, never shorter than the minimum pulse
    task automatic pulse(input int idx, input int len);
        @(negedge sys_clk_in);
        trans_req_out[idx] = 1'b1;
        repeat ((len < MIN_PULSE) ? MIN_PULSE : len) @(negedge sys_clk_in);
        trans_req_out[idx] = 1'b0;
    endtask

    // set many levels at once, used for competing and chained requests
    task automatic hold(input logic [NUM_REQ-1:0] v);
        @(negedge sys_clk_in);
        trans_req_out = v;
    endtask

    // drive the return line, low while asked
    task automatic ret(input logic low);
        @(negedge sys_clk_in);
        ret_n_out = ~low;
    endtask
endmodule

// File: esm_top_tb.sv
// self-checking bench for the event state machine
`timescale 1ns/1ps
module esm_top_tb;
    import esm_pkg::*;

    logic                 sys_clk_in;              // bench clock
    logic                 srst_in;                 // synchronous reset
    logic                 cfg_wr_in;               // write strobe
    logic                 cfg_rd_in;               // read strobe
    logic [7:0]           cfg_addr_in;             // byte address
    logic [7:0]           cfg_wdata_in;            // write byte
    logic [NUM_REQ-1:0]   trans_req_in;            // from matrix model
    logic                 return_to_initial_n_in;  // from matrix model
    logic [OUT_WIDTH-1:0] state_output_out;        // machine outputs
    logic [2:0]           state_out;               // current state
    logic [7:0]           cfg_rdata_out;           // read byte
    logic                 cfg_rvalid_out;          // read valid
    int                   miscompares;             // mismatches seen
    int                   cmp_count;               // comparisons made
    logic [7:0]           tbl [NUM_STATES];        // expected output table
    logic [7:0]           rd;                      // last read byte
    logic [2:0]           r;                       // random initial state

    esm_top dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .trans_req_in(trans_req_in),
        .return_to_initial_n_in(return_to_initial_n_in), .cfg_wr_in(cfg_wr_in),
        .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
        .state_output_out(state_output_out), .state_out(state_out),
        .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out));

    esm_matrix_model pm (.sys_clk_in(sys_clk_in), .trans_req_out(trans_req_in),
        .ret_n_out(return_to_initial_n_in));

    // 100 mhz clock
    always #5 sys_clk_in = ~sys_clk_in;

    ////////////////////////////////////////////////////////////////////////
    // slot byte for an enabled transition from a source state
    function automatic logic [7:0] slot_byte(input logic [2:0] src);
        return 8'h80 | {5'h00, src};
    endfunction

    // ring slot leading into state d: first of its group, slot 2 for state 0
    function automatic int ring_slot(input int d);
        return (d % NUM_STATES == 0) ? 2 : 3 * (d % NUM_STATES);
    endfunction

    // compare one value and count it
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        cfg_wr_in    = 1'b1;
        cfg_addr_in  = a;
        cfg_wdata_in = d;
        @(negedge sys_clk_in);
        cfg_wr_in    = 1'b0;
        cfg_wdata_in = 8'($urandom);
    endtask

    // write strobe followed at once by a read of the same byte
    task automatic cfg_write_read(input logic [7:0] a, input logic [7:0] d,
                                  output logic [7:0] q);
        @(negedge sys_clk_in);
        cfg_wr_in    = 1'b1;
        cfg_addr_in  = a;
        cfg_wdata_in = d;
        @(negedge sys_clk_in);
        cfg_wr_in = 1'b0;
        cfg_rd_in = 1'b1;
        @(negedge sys_clk_in);
        cfg_rd_in   = 1'b0;
        cfg_addr_in = 8'($urandom);
        // rvalid stands between the edge that took the read and the next one
        check("rvalid", 8'h01, {7'h00, cfg_rvalid_out});
        q = cfg_rdata_out;
    endtask

    // one-cycle read strobe, valid from the edge that takes it
    task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_in);
        cfg_rd_in   = 1'b1;
        cfg_addr_in = a;
        @(negedge sys_clk_in);
        cfg_rd_in   = 1'b0;
        cfg_addr_in = 8'($urandom);
        // rvalid stands between the edge that took the read and the next one
        check("rvalid", 8'h01, {7'h00, cfg_rvalid_out});
        d = cfg_rdata_out;
    endtask

    // wait for a state under a bound, then check state and outputs
    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 12 && state_out !== s; i++) begin
            @(posedge sys_clk_in);
            #1;
        end
        check("state", {5'h00, s}, {5'h00, state_out});
        check("outputs", tbl[s], state_output_out);
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200us;
        miscompares++;
        complete_run();
    end

    // main sequence
    initial begin
        sys_clk_in = 1'b0;
        srst_in = 1'b1;
        void'($urandom(32'h7b81));
        {cfg_wr_in, cfg_rd_in} = '0;
        cfg_addr_in  = 8'($urandom);
        cfg_wdata_in = 8'($urandom);
        miscompares = 0;
        cmp_count = 0;
        repeat (20) @(negedge sys_clk_in);
        srst_in = 1'b0;
        // reset contents: one-hot table, slots off, initial state 0
        for (int n = 0; n < NUM_STATES; n++) begin
            tbl[n] = 8'h01 << n;
            cfg_read(OTAB_BASE + 8'(n), rd);
            check("table reset", tbl[n], rd);
        end
        check("outputs reset", 8'h01, state_output_out);
        for (int k = 0; k < NUM_REQ; k++) begin
            cfg_read(TRANS_BASE + 8'(k), rd);
            check("slot reset", TRANS_RESET, rd);
        end
        cfg_read(8'he5, rd);
        check("unmapped", 8'h00, rd);
        // random table, outputs keep old level until a state change
        for (int n = 0; n < NUM_STATES; n++) begin
            tbl[n] = 8'($urandom);
            cfg_write_read(OTAB_BASE + 8'(n), tbl[n], rd);
            check("table rw", tbl[n], rd);
        end
        check("outputs held", 8'h01, state_output_out);
        cfg_write(STATE_ADDR, 8'h05);
        cfg_read(STATE_ADDR, rd);
        check("state ro", 8'h00, rd);
        // ring d-1 -> d on the first slot of each destination, 7 -> 0 on slot 2
        for (int d = 1; d < NUM_STATES; d++)
            cfg_write(8'(3 * d), slot_byte(3'(d - 1)));
        cfg_write(8'h02, slot_byte(3'h7));
        cfg_read(8'h02, rd);
        check("slot rw", 8'h87, rd);
        pm.pulse(3, 4);
        wait_state(3'h1);
        // two exits from state 1 at once: lowest slot wins
        cfg_write(8'h0c, slot_byte(3'h1));
        pm.hold(24'h001040);
        wait_state(3'h2);
        pm.hold('0);
        // pending exit from the next state fires one cycle after entry
        cfg_write(8'h0c, slot_byte(3'h3));
        pm.hold(24'h001200);
        wait_state(3'h3);
        @(posedge sys_clk_in);
        #1;
        check("chained state", 8'h04, {5'h00, state_out});
        pm.hold('0);
        // walk the ring back to state 0 with random pulse lengths
        for (int d = 5; d <= NUM_STATES; d++) begin
            pm.pulse(ring_slot(d), $urandom_range(3, 8));
            wait_state(3'(d % NUM_STATES));
        end
        // return to a random initial state; table writes show while held
        r = 3'($urandom_range(1, 7));
        cfg_write(INIT_ADDR, {5'h00, r});
        pm.ret(1'b1);
        wait_state(r);
        tbl[r] = ~tbl[r];
        cfg_write(OTAB_BASE + {5'h00, r}, tbl[r]);
        repeat (2) @(posedge sys_clk_in);
        #1;
        check("table in reset", tbl[r], state_output_out);
        cfg_read(INIT_ADDR, rd);
        check("init rw", {5'h00, r}, rd);
        cfg_read(STATE_ADDR, rd);
        check("state read", {5'h00, r}, rd);
        pm.pulse(ring_slot(int'(r) + 1), 4);
        check("return wins", {5'h00, r}, {5'h00, state_out});
        pm.ret(1'b0);
        // second reset mid-run
        @(negedge sys_clk_in);
        srst_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        srst_in = 1'b0;
        check("state after reset", 8'h00, {5'h00, state_out});
        check("outputs after reset", 8'h01, state_output_out);
        cfg_read(OTAB_BASE + 8'h07, rd);
        check("table after reset", 8'h80, rd);
        // a slot leading into the current state is ignored
        cfg_write(8'h01, slot_byte(3'h0));
        pm.pulse(1, 4);
        repeat (2) @(posedge sys_clk_in);
        #1;
        check("no self transition", 8'h00, {5'h00, state_out});
        complete_run();
    end
endmodule
